// File: hw/rpd_regs.vh
// Register offsets, field positions and reset values for the regulator register bank
`ifndef RPD_REGS_VH
`define RPD_REGS_VH

`define RPD_ADDR_W          8
`define RPD_OFF_BUCK1_OP2   8'h09
`define RPD_OFF_BUCK2_OP2   8'h0B
`define RPD_OFF_BUCK_CTRL   8'h0C
`define RPD_OFF_DISCHARGE   8'h0E
`define RPD_OFF_STATUS      8'h0F

`define RPD_CL_HI           7
`define RPD_CL_LO           6
`define RPD_CTRL_PWM1       2
`define RPD_CTRL_PWM2       3
`define RPD_CTRL_MASK1      4
`define RPD_CTRL_MASK2      5
`define RPD_DIS_KEEP        7

`define RPD_STS_TSD         0
`define RPD_STS_CONV1       1
`define RPD_STS_CONV2       2
`define RPD_STS_REG1        3
`define RPD_STS_REV_LO      4

`define RPD_RST_BUCK1_OP2   8'hC8
`define RPD_RST_BUCK2_OP2   8'h91
`define RPD_RST_BUCK_CTRL   8'h00
`define RPD_RST_DISCHARGE   8'h7F

// Arbitrary neutral revision code
`define RPD_MASK_REVISION   4'h1

`endif

// File: hw/rpd_sync2.v
// Two-flop synchroniser for a bus of asynchronous levels
module rpd_sync2 #(
	parameter W = 4
) (
	// Clock and reset
	input  wire         ref_clk,
	input  wire         rst,
	// Levels
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] stage1;

	always @(posedge ref_clk) begin
		if (rst) begin
			stage1   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// File: hw/rpd_restart.v
// Thermal shutdown watcher: restart request and register reload decision
module rpd_restart (
	// Clock and reset
	input  wire ref_clk,
	input  wire rst,
	// Synchronised conditions
	input  wire tsd_sync,
	input  wire enable_sync,
	input  wire standalone_sync,
	input  wire keep_regs,
	// Actions
	output reg  reload_defaults,
	output reg  restart_pulse
);
	reg tsd_prev;
	wire cool_edge;

	assign cool_edge = tsd_prev & ~tsd_sync;

	always @(posedge ref_clk) begin
		if (rst) begin
			tsd_prev        <= 1'b0;
			reload_defaults <= 1'b0;
			restart_pulse   <= 1'b0;
		end else begin
			tsd_prev        <= tsd_sync;
			// Reload and restart pulse are registered on the same edge
			reload_defaults <= cool_edge & enable_sync & ~keep_regs & standalone_sync;
			restart_pulse   <= cool_edge & enable_sync;
		end
	end
endmodule

// File: hw/rpd_regbank.v
// Regulator pull-down, converter control and status register bank

`include "rpd_regs.vh"

module rpd_regbank (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       rst,
	// Register access from the serial interface
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	// Device pins and analog status
	input  wire       enable_pin,
	input  wire       config_standalone,
	input  wire       thermal_shutdown_in,
	input  wire       conv1_out_of_reg_in,
	input  wire       conv2_out_of_reg_in,
	input  wire       reg1_out_of_reg_in,
	// Regulator pull-downs
	output reg        reg1_discharge_en,
	output reg        reg2_discharge_en,
	output reg        reg3_discharge_en,
	output reg        reg4_discharge_en,
	output reg        reg5_discharge_en,
	output reg        lowv_reg1_discharge_en,
	output reg        lowv_reg2_discharge_en,
	// Converter controls
	output reg  [1:0] conv1_current_limit,
	output reg  [1:0] conv2_current_limit,
	output reg        conv1_force_pwm,
	output reg        conv2_force_pwm,
	// Sequencer
	output reg        startup_restart
);
	reg  [7:0] discharge_ctrl;
	reg  [7:0] buck1_op2;
	reg  [7:0] buck2_op2;
	reg  [7:0] buck_ctrl;
	reg  [7:0] next_rdata;
	wire [3:0] status_sync;
	wire       tsd_s;
	wire       en_s;
	wire       cfg_s;
	wire       reload_defaults;
	wire       restart_pulse;
	wire [7:0] status_word;

	function wr_hit;
		input [7:0] addr;
		input [7:0] off;
		input       wr;
		begin
			wr_hit = wr && (addr == off);
		end
	endfunction

	rpd_sync2 #(
		.W(4)
	) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in ({reg1_out_of_reg_in, conv2_out_of_reg_in, conv1_out_of_reg_in,
			thermal_shutdown_in}),
		.sync_out (status_sync)
	);

	reg en_s1;
	reg en_s2;
	reg cfg_s1;
	reg cfg_s2;

	// Enable pin, two flops before any logic reads it
	always @(posedge ref_clk) begin
		if (rst) begin
			en_s1 <= 1'b0;
			en_s2 <= 1'b0;
		end else begin
			en_s1 <= enable_pin;
			en_s2 <= en_s1;
		end
	end

	// Role strap, two flops before any logic reads it
	always @(posedge ref_clk) begin
		if (rst) begin
			cfg_s1 <= 1'b0;
			cfg_s2 <= 1'b0;
		end else begin
			cfg_s1 <= config_standalone;
			cfg_s2 <= cfg_s1;
		end
	end

	assign en_s  = en_s2;
	assign cfg_s = cfg_s2;
	assign tsd_s = status_sync[0];

	rpd_restart u_restart (
		.ref_clk         (ref_clk),
		.rst             (rst),
		.tsd_sync        (tsd_s),
		.enable_sync     (en_s),
		.standalone_sync (cfg_s),
		.keep_regs       (discharge_ctrl[`RPD_DIS_KEEP]),
		.reload_defaults (reload_defaults),
		.restart_pulse   (restart_pulse)
	);

	// Reload only when policy bit clear; reload beats a write in the same cycle
	always @(posedge ref_clk) begin
		if (rst || reload_defaults) begin
			discharge_ctrl <= `RPD_RST_DISCHARGE;
		end else if (wr_hit(reg_addr, `RPD_OFF_DISCHARGE, reg_wr)) begin
			discharge_ctrl <= reg_wdata;
		end
	end

	always @(posedge ref_clk) begin
		if (rst || reload_defaults) begin
			buck1_op2 <= `RPD_RST_BUCK1_OP2;
		end else if (wr_hit(reg_addr, `RPD_OFF_BUCK1_OP2, reg_wr)) begin
			buck1_op2 <= reg_wdata;
		end
	end

	always @(posedge ref_clk) begin
		if (rst || reload_defaults) begin
			buck2_op2 <= `RPD_RST_BUCK2_OP2;
		end else if (wr_hit(reg_addr, `RPD_OFF_BUCK2_OP2, reg_wr)) begin
			buck2_op2 <= reg_wdata;
		end
	end

	always @(posedge ref_clk) begin
		if (rst || reload_defaults) begin
			buck_ctrl <= `RPD_RST_BUCK_CTRL;
		end else if (wr_hit(reg_addr, `RPD_OFF_BUCK_CTRL, reg_wr)) begin
			buck_ctrl <= reg_wdata;
		end
	end

	// Status offset has no write path at all

	// Masked converter flags read as in regulation
	function [7:0] status_byte;
		input [3:0] flags;
		input [7:0] ctrl;
		begin
			status_byte = {`RPD_MASK_REVISION,
				flags[3],
				flags[2] & ~ctrl[`RPD_CTRL_MASK2],
				flags[1] & ~ctrl[`RPD_CTRL_MASK1],
				flags[0]};
		end
	endfunction

	assign status_word = status_byte(status_sync, buck_ctrl);

	always @* begin
		next_rdata = 8'h00;
		case (reg_addr)
			`RPD_OFF_DISCHARGE: next_rdata = discharge_ctrl;
			`RPD_OFF_BUCK1_OP2: next_rdata = buck1_op2;
			`RPD_OFF_BUCK2_OP2: next_rdata = buck2_op2;
			`RPD_OFF_BUCK_CTRL: next_rdata = buck_ctrl;
			`RPD_OFF_STATUS:    next_rdata = status_word;
			default:            next_rdata = 8'h00;
		endcase
	end

	// Read data holds until the next read strobe
	always @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// Pull-down drives trail their register by one flop
	always @(posedge ref_clk) begin
		if (rst) begin
			reg1_discharge_en <= 1'b0;
		end else begin
			reg1_discharge_en <= discharge_ctrl[0];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			reg2_discharge_en <= 1'b0;
		end else begin
			reg2_discharge_en <= discharge_ctrl[1];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			reg3_discharge_en <= 1'b0;
		end else begin
			reg3_discharge_en <= discharge_ctrl[2];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			reg4_discharge_en <= 1'b0;
		end else begin
			reg4_discharge_en <= discharge_ctrl[3];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			reg5_discharge_en <= 1'b0;
		end else begin
			reg5_discharge_en <= discharge_ctrl[4];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			lowv_reg1_discharge_en <= 1'b0;
		end else begin
			lowv_reg1_discharge_en <= discharge_ctrl[5];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			lowv_reg2_discharge_en <= 1'b0;
		end else begin
			lowv_reg2_discharge_en <= discharge_ctrl[6];
		end
	end

	// Converter controls, glitch-free to the analog side
	always @(posedge ref_clk) begin
		if (rst) begin
			conv1_current_limit <= 2'b00;
		end else begin
			conv1_current_limit <= buck1_op2[`RPD_CL_HI:`RPD_CL_LO];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			conv2_current_limit <= 2'b00;
		end else begin
			conv2_current_limit <= buck2_op2[`RPD_CL_HI:`RPD_CL_LO];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			conv1_force_pwm <= 1'b0;
		end else begin
			conv1_force_pwm <= buck_ctrl[`RPD_CTRL_PWM1];
		end
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			conv2_force_pwm <= 1'b0;
		end else begin
			conv2_force_pwm <= buck_ctrl[`RPD_CTRL_PWM2];
		end
	end

	// Start pulse lands with the reloaded registers
	always @(posedge ref_clk) begin
		if (rst) begin
			startup_restart <= 1'b0;
		end else begin
			startup_restart <= restart_pulse;
		end
	end
endmodule

// File: dv/rpd_checker.sv
// Port timing checker for the regulator register bank
`include "rpd_regs.vh"
module rpd_checker (
	// Clock, reset, strobes and pins
	input wire       ref_clk, rst, reg_wr, reg_rd, enable_pin, thermal_shutdown_in,
	// Register bus
	input wire [7:0] reg_addr, reg_wdata, reg_rdata,
	// Controls
	input wire       reg1_discharge_en, lowv_reg2_discharge_en, conv1_force_pwm, startup_restart,
	input wire [1:0] conv1_current_limit
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	property p_dis;
		reg_wr && reg_addr == 8'h0E |-> ##2 reg1_discharge_en == $past(reg_wdata[0], 2);
	endproperty
	a_dis: assert property (p_dis) else $error("discharge output lags write");
	// Output flop trails the register by one edge, as does read data
	property p_rdb;
		reg_rd && reg_addr == 8'h0E && !$past(rst) |=>
			{reg_rdata[6], reg_rdata[0]} == {lowv_reg2_discharge_en, reg1_discharge_en};
	endproperty
	a_rdb: assert property (p_rdb) else $error("discharge readback mismatch");
	property p_cl;
		reg_wr && reg_addr == 8'h09 |-> ##2 conv1_current_limit == $past(reg_wdata[7:6], 2);
	endproperty
	a_cl: assert property (p_cl) else $error("current limit mismatch");
	property p_pwm;
		reg_wr && reg_addr == 8'h0C |-> ##2 conv1_force_pwm == $past(reg_wdata[2], 2);
	endproperty
	a_pwm: assert property (p_pwm) else $error("force pwm mismatch");
	property p_rev;
		reg_rd && reg_addr == 8'h0F |=> reg_rdata[7:4] == `RPD_MASK_REVISION;
	endproperty
	a_rev: assert property (p_rev) else $error("revision field wrong");
	property p_tsd;
		thermal_shutdown_in [*4] ##0 (reg_rd && reg_addr == 8'h0F) |=> reg_rdata[0];
	endproperty
	a_tsd: assert property (p_tsd) else $error("shutdown flag not shown");
	property p_rst;
		$fell(thermal_shutdown_in) && enable_pin |-> ##[1:8] startup_restart;
	endproperty
	a_rst: assert property (p_rst) else $error("no restart after shutdown");
	property p_pls;
		startup_restart |=> !startup_restart;
	endproperty
	a_pls: assert property (p_pls) else $error("restart pulse too long");
endmodule

// File: dv/rpd_host.sv
// Host model issuing single-byte register cycles
module rpd_host (
	input  wire       ref_clk,
	input  wire [7:0] reg_rdata,
	output reg  [7:0] reg_addr,
	output reg  [7:0] reg_wdata,
	output reg        reg_wr,
	output reg        reg_rd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h0_0000;
	task cyc(input bit w, input [7:0] a, input [7:0] d, output [7:0] q);
		@(posedge ref_clk);
		#1 {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
		@(posedge ref_clk);
		#1 {reg_wr, reg_rd} = 2'h0;
		// Extra edge so read data has surely landed
		@(posedge ref_clk);
		#1 q = reg_rdata;
	endtask
endmodule

// File: dv/rpd_regbank_tb.sv
// Self-checking bench for the regulator register bank
`include "rpd_regs.vh"
bind rpd_regbank rpd_checker chk (.ref_clk, .rst, .reg_wr, .reg_rd, .enable_pin,
	.thermal_shutdown_in, .reg_addr, .reg_wdata, .reg_rdata, .reg1_discharge_en,
	.lowv_reg2_discharge_en, .conv1_force_pwm, .startup_restart, .conv1_current_limit);
module rpd_regbank_tb;
	timeunit 1ns;
	timeprecision 100ps;
	reg        ref_clk = 1'h0, rst = 1'h1, sa = 1'h1, thermal_shutdown_flag = 1'h0, en = 1'h1;
	reg  [2:0] flags = 3'h0;
	wire [7:0] reg_addr, reg_wdata, reg_rdata;
	wire       reg_wr, reg_rd, restart, pwm1, pwm2;
	wire [6:0] dis;
	wire [1:0] cl1, cl2;
	int        m[int], num_errors = 0, n_compared = 0, cyc = 0, i, k;
	bit [31:0] seed = 32'h944d_5985;
	reg  [7:0] q, a, ad[6] = '{8'h09, 8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h3A};
	always #2 ref_clk = ~ref_clk;
	rpd_host host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	rpd_regbank dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enable_pin(en),
		.config_standalone(sa), .thermal_shutdown_in(thermal_shutdown_flag), .conv1_out_of_reg_in(flags[0]),
		.conv2_out_of_reg_in(flags[1]), .reg1_out_of_reg_in(flags[2]),
		.reg1_discharge_en(dis[0]), .reg2_discharge_en(dis[1]), .reg3_discharge_en(dis[2]),
		.reg4_discharge_en(dis[3]), .reg5_discharge_en(dis[4]), .lowv_reg1_discharge_en(dis[5]),
		.lowv_reg2_discharge_en(dis[6]), .conv1_current_limit(cl1), .conv2_current_limit(cl2),
		.conv1_force_pwm(pwm1), .conv2_force_pwm(pwm2), .startup_restart(restart));
	function automatic [31:0] rnd;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input string nm, input [7:0] seen, input [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task dflt;
		m[9] = 8'hC8; m[11] = 8'h91; m[12] = 8'h00; m[14] = 8'h7F;
	endtask
	task rd_chk(input [7:0] x);
		host.cyc(0, x, 8'h00, q);
		if (x == 8'h0F)
			chk("status", q, {`RPD_MASK_REVISION, flags[2], flags[1] & ~m[12][5],
				flags[0] & ~m[12][4], thermal_shutdown_flag});
		else
			chk("readback", q, m.exists(x) ? m[x][7:0] : 8'h00);
	endtask
	task outs_chk;
		chk("discharge", {1'h0, dis}, {1'h0, m[14][6:0]});
		chk("converter", {cl2, cl1, pwm2, pwm1, 2'h0},
			{m[11][7:6], m[9][7:6], m[12][3:2], 2'h0});
	endtask
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		if (++cyc == 5000) begin
			num_errors++;
			final_report();
		end
	end
	initial begin
		dflt();
		repeat (8) @(posedge ref_clk);
		#1 rst = 1'h0;
		foreach (ad[j]) rd_chk(ad[j]);
		outs_chk();
		$display("test reset done");
		for (i = 0; i < 30; i++) begin
			k = rnd();
			flags = k[2:0];
			a = ad[rnd() % 6];
			k = rnd();
			host.cyc(1, a, k[7:0], q);
			if (m.exists(a)) m[a] = k[7:0];
			@(posedge ref_clk);
			#1 outs_chk();
			rd_chk(a);
			rd_chk(8'h0F);
		end
		$display("test random access done");
		// Cases: keep, reload stand-alone, no reload in module role, no restart with enable low
		for (k = 0; k < 4; k++) begin
			sa = (k != 2);
			en = (k != 3);
			host.cyc(1, 8'h0E, {k == 0, 7'h15}, q);
			m[14] = {k == 0, 7'h15};
			host.cyc(1, 8'h09, 8'h40, q);
			m[9] = 8'h40;
			thermal_shutdown_flag = 1'h1;
			rd_chk(8'h0E);
			rd_chk(8'h0F);
			thermal_shutdown_flag = 1'h0;
			for (i = 0; i < 12 && restart !== 1'h1; i++) @(posedge ref_clk) #1;
			chk("restart", {7'h0, restart}, {7'h0, en});
			if (k == 1) dflt();
			repeat (2) @(posedge ref_clk);
			#1 outs_chk();
			rd_chk(8'h09);
		end
		$display("test thermal restart done");
		final_report();
	end
endmodule
